// ---- sar_adc_analog.sv ----
// Analog source model: channel levels, comparator and RC oscillator.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_analog (
  input wire logic SYS_CLK,
  input wire sar_adc_pkg::analog_ctl_t ANALOG_CTL,
  input wire logic [sar_adc_pkg::RES_W-1:0] DAC_CODE,
  output logic COMPARE_HIGH,
  output logic RC_TICK
);
  import sar_adc_pkg::*;
  logic [RES_W-1:0] lvl;
  logic noise = 1'b0;
  always_comb begin
    case (ANALOG_CTL.channel)
      CH_REF_POS: lvl = 10'h3FF;
      CH_REF_NEG: lvl = 10'h000;
      default: lvl = {ANALOG_CTL.channel, ~ANALOG_CTL.channel};
    endcase
  end
  // half bit period of 800 ns.
  initial begin
    RC_TICK = 1'b0;
    forever #400 RC_TICK = ~RC_TICK;
  end
  always @(posedge SYS_CLK) noise <= ~noise;
  // The input sits half a step above its code, so the result is exact.
  // a cut-off input has no steady level.
  assign COMPARE_HIGH = ANALOG_CTL.mux_connect ? (DAC_CODE <= lvl) : noise;
endmodule : sar_adc_analog
`default_nettype wire

// ---- sar_adc_control.sv ----
// Control logic of a 10-bit successive-approximation converter.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control #(
  parameter int INSTR_CYCLES = 4
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic RC_TICK,
  input wire logic SLEEP_REQ,
  input wire logic COMPARE_HIGH,
  output sar_adc_pkg::analog_ctl_t ANALOG_CTL,
  output logic [sar_adc_pkg::RES_W-1:0] DAC_CODE,
  output logic SAMPLE,
  output logic CONV_IRQ,
  output logic WAKE_REQ
);
  import sar_adc_pkg::*;
  // The start delay counter holds INSTR_CYCLES - 1 in eight bits.
  if (INSTR_CYCLES < 1 || INSTR_CYCLES > 255) begin : g_bad_cycles
    $error("INSTR_CYCLES out of range");
  end
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic rc_prev_ff;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      rc_prev_ff <= 1'b0;
    end else begin
      sync1_ff <= {RC_TICK, SLEEP_REQ, COMPARE_HIGH};
      sync2_ff <= sync1_ff;
      rc_prev_ff <= sync2_ff[2];
    end
  end
  logic rc_edge;
  logic sleep_s;
  logic cmp_s;
  assign rc_edge = sync2_ff[2] & ~rc_prev_ff;
  assign sleep_s = sync2_ff[1];
  assign cmp_s = sync2_ff[0];

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave, no wait states; a read just behind a write sees old data.
  logic [11:0] addr_ff;
  logic wr_ff;
  logic take;
  assign take = HSEL & HREADY & (HTRANS == HTRANS_NONSEQ) &
                (HSIZE == HSIZE_WORD);
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      addr_ff <= 12'h000;
      wr_ff <= 1'b0;
    end else begin
      addr_ff <= HADDR[11:0];
      wr_ff <= take & HWRITE;
    end
  end
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction : hit
  logic enable_ff;
  logic go_ff;
  logic [CHAN_W-1:0] chan_ff;
  logic [1:0] ref_ff;
  logic [2:0] clk_sel_ff;
  logic justify_ff;
  logic flag_ff;
  logic irq_en_ff;
  logic [7:0] vref_ff;
  logic [RES_W-1:0] result_ff;
  conv_state_t state_ff;
  logic done_evt;
  logic abort_evt;
  logic sleep_off;
  logic [RES_W-1:0] part_val;
  logic wr0;
  assign wr0 = wr_ff & hit(addr_ff, OFS_CTRL0);

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      enable_ff <= 1'b0;
      chan_ff <= 5'h00;
    end else if (wr0) begin
      enable_ff <= HWDATA[C0_ENABLE];
      chan_ff <= HWDATA[C0_CHAN_LSB +: CHAN_W];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      go_ff <= 1'b0;
    end else if (done_evt || sleep_off) begin
      go_ff <= 1'b0;
    end else if (wr0) begin
      go_ff <= HWDATA[C0_GO] & enable_ff;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ref_ff <= 2'h0;
      clk_sel_ff <= 3'h0;
      justify_ff <= 1'b0;
      irq_en_ff <= 1'b0;
      vref_ff <= 8'h00;
    end else begin
      if (wr_ff && hit(addr_ff, OFS_CTRL1)) begin
        ref_ff <= HWDATA[C1_REF_LSB +: 2];
        clk_sel_ff <= HWDATA[C1_CLK_LSB +: 3];
        justify_ff <= HWDATA[C1_JUSTIFY];
      end
      if (wr_ff && hit(addr_ff, OFS_IRQ_EN)) begin
        irq_en_ff <= HWDATA[0];
      end
      if (wr_ff && hit(addr_ff, OFS_VREF)) begin
        vref_ff <= HWDATA[VREF_MASK_W-1:0] & VREF_RW_MASK;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flag_ff <= 1'b0;
    end else if (done_evt) begin
      flag_ff <= 1'b1;
    end else if (wr_ff && hit(addr_ff, OFS_FLAG) && !HWDATA[0]) begin
      flag_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion clock and sequencer.
  logic rc_sel;
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] half_len;
  assign rc_sel = (clk_sel_ff[1:0] == CLK_RC_LOW);
  assign half_len = DIV_W'(1) << {clk_sel_ff[1:0], clk_sel_ff[2]};
  logic half_tick;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_ff <= 7'h00;
    end else if (state_ff != ST_CONVERT || half_tick) begin
      div_ff <= 7'h00;
    end else begin
      div_ff <= div_ff + 7'h01;
    end
  end
  assign half_tick = rc_sel ? rc_edge : (div_ff == half_len - 7'h01);
  assign sleep_off = sleep_s & ~rc_sel & (state_ff != ST_IDLE);
  logic [STEP_W-1:0] step_ff;
  logic [7:0] delay_ff;
  logic [RES_W-1:0] sar_ff;
  logic [3:0] bit_ff;
  assign abort_evt = wr0 & ~HWDATA[C0_GO] & (state_ff == ST_CONVERT);
  assign done_evt = (state_ff == ST_CONVERT) & half_tick &
                    (step_ff == STEP_W'(HALF_STEPS - 1));

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= ST_IDLE;
      step_ff <= 5'h00;
      delay_ff <= 8'h00;
      sar_ff <= 10'h000;
      bit_ff <= 4'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (go_ff && enable_ff && !(sleep_s && !rc_sel)) begin
            state_ff <= rc_sel ? ST_DELAY : ST_CONVERT;
            delay_ff <= 8'(INSTR_CYCLES - 1);
            step_ff <= 5'h00;
            sar_ff <= 10'h200;
            bit_ff <= 4'h9;
          end
        end
        ST_DELAY: begin
          if (!go_ff || sleep_off) begin
            state_ff <= ST_IDLE;
          end else if (delay_ff == 8'h00) begin
            state_ff <= ST_CONVERT;
          end else begin
            delay_ff <= delay_ff - 8'h01;
          end
        end
        ST_CONVERT: begin
          if (abort_evt || sleep_off || done_evt) begin
            state_ff <= ST_IDLE;
          end else if (half_tick) begin
            step_ff <= step_ff + 5'h01;
            if (step_ff[0] == 1'b0 && step_ff != 5'h00) begin
              sar_ff[bit_ff] <= cmp_s;
              if (bit_ff != 4'h0) begin
                sar_ff[bit_ff - 4'h1] <= 1'b1;
                bit_ff <= bit_ff - 4'h1;
              end
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  always_comb begin
    part_val = sar_ff;
    for (int i = 0; i < RES_W; i++) begin
      if (i <= int'(bit_ff)) begin
        part_val[i] = (bit_ff == 4'h9) ? 1'b0 : sar_ff[bit_ff + 4'h1];
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      result_ff <= 10'h000;
    end else if (done_evt) begin
      // The last bit landed two half steps ago, so the trial word is final.
      result_ff <= sar_ff;
    end else if (abort_evt) begin
      result_ff <= part_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog controls and read mux.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ANALOG_CTL <= '0;
      DAC_CODE <= 10'h000;
      SAMPLE <= 1'b0;
    end else begin
      ANALOG_CTL.channel <= chan_ff;
      ANALOG_CTL.mux_connect <= enable_ff & valid_chan(chan_ff);
      ANALOG_CTL.pos_ref <= ref_ff;
      DAC_CODE <= sar_ff;
      SAMPLE <= (state_ff != ST_CONVERT) & enable_ff & valid_chan(chan_ff);
    end
  end

  function automatic logic valid_chan(input logic [4:0] c);
    valid_chan = (c <= CH_PIN_LO) || (c >= CH_PIN_LO8 && c <= CH_PIN_HI) ||
                 c == CH_REF_POS || c == CH_REF_NEG || c == CH_TEMP ||
                 c == CH_FIXED_REF;
  endfunction : valid_chan
  logic [15:0] pair;
  assign pair = justify_ff ? {6'h00, result_ff} : {result_ff, 6'h00};
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    case (HADDR[11:0])
      OFS_CTRL0: rdata[7:0] = {1'b0, chan_ff, go_ff, enable_ff};
      OFS_CTRL1: rdata[7:0] = {justify_ff, clk_sel_ff, 2'h0, ref_ff};
      OFS_RES_HIGH: rdata[7:0] = pair[15:8];
      OFS_RES_LOW: rdata[7:0] = pair[7:0];
      OFS_FLAG: rdata[0] = flag_ff;
      OFS_IRQ_EN: rdata[0] = irq_en_ff;
      OFS_VREF: rdata[7:0] = vref_ff | VREF_READY_BIT;
      OFS_MODE: rdata[2:0] = {sleep_s, 2'(state_ff)};
      default: rdata = 32'h0000_0000;
    endcase
  end
  // Registered at the address phase so that it stands in the data phase.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      HRDATA <= 32'h0000_0000;
    end else begin
      HRDATA <= (take && !HWRITE) ? rdata : 32'h0000_0000;
    end
  end
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CONV_IRQ <= 1'b0;
      WAKE_REQ <= 1'b0;
    end else begin
      CONV_IRQ <= flag_ff & irq_en_ff;
      WAKE_REQ <= flag_ff & irq_en_ff & sleep_s;
    end
  end
endmodule : sar_adc_control
`default_nettype wire

// ---- sar_adc_pkg.sv ----
// Package for the successive-approximation converter control block.
package sar_adc_pkg;
  localparam int DATA_W = 32;
  localparam int RES_W = 10;
  // Byte addresses of the register words.
  localparam logic [11:0] OFS_CTRL0 = 12'h000;
  localparam logic [11:0] OFS_CTRL1 = 12'h004;
  localparam logic [11:0] OFS_RES_HIGH = 12'h008;
  localparam logic [11:0] OFS_RES_LOW = 12'h00C;
  localparam logic [11:0] OFS_FLAG = 12'h010;
  localparam logic [11:0] OFS_IRQ_EN = 12'h014;
  localparam logic [11:0] OFS_VREF = 12'h018;
  localparam logic [11:0] OFS_MODE = 12'h01C;
  // Control word 0 fields.
  localparam int C0_ENABLE = 0;
  localparam int C0_GO = 1;
  localparam int C0_CHAN_LSB = 2;
  localparam int CHAN_W = 5;
  // Control word 1 fields.
  localparam int C1_REF_LSB = 0;
  localparam int C1_CLK_LSB = 4;
  localparam int C1_JUSTIFY = 7;
  localparam int VREF_MASK_W = 8;
  localparam logic [7:0] VREF_RW_MASK = 8'hB3;
  localparam logic [7:0] VREF_READY_BIT = 8'h40;
  // Clock-select codes; low two bits 11 pick the RC oscillator.
  localparam logic [1:0] CLK_RC_LOW = 2'h3;
  // Channel codes.
  localparam logic [4:0] CH_TEMP = 5'h1D;
  localparam logic [4:0] CH_FIXED_REF = 5'h1F;
  localparam logic [4:0] CH_REF_NEG = 5'h1B;
  localparam logic [4:0] CH_REF_POS = 5'h1A;
  localparam logic [4:0] CH_PIN_HI = 5'h13;
  localparam logic [4:0] CH_PIN_LO8 = 5'h08;
  localparam logic [4:0] CH_PIN_LO = 5'h04;
  localparam logic [1:0] REF_RESERVED = 2'h1;
  // Half bit-periods of a whole conversion: three overhead halves plus ten bits.
  localparam int HALF_STEPS = 23;
  localparam int STEP_W = 5;
  localparam int DIV_W = 7;
  // AHB-Lite transfer types and sizes.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONVERT} conv_state_t;

  typedef struct packed {
    logic [CHAN_W-1:0] channel;
    logic mux_connect;
    logic [1:0] pos_ref;
  } analog_ctl_t;
endpackage : sar_adc_pkg

// ---- sar_adc_props.sv ----
// Port checker of the converter control block.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_props (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic SAMPLE,
  input wire sar_adc_pkg::analog_ctl_t ANALOG_CTL,
  input wire logic CONV_IRQ,
  input wire logic WAKE_REQ
);
  import sar_adc_pkg::*;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  logic wr_ff, rd_ff, en_ff, ien_ff, hit;
  logic [11:0] adr_ff;
  logic [CHAN_W-1:0] ch_ff;
  assign hit = HSEL && HREADY && HTRANS == HTRANS_NONSEQ
    && HSIZE == HSIZE_WORD;
  // Shadow copies of the control bits, tracked from bus writes.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      adr_ff <= 12'h0;
      en_ff <= 1'b0;
      ch_ff <= '0;
      ien_ff <= 1'b0;
    end else begin
      wr_ff <= hit && HWRITE;
      rd_ff <= hit && !HWRITE;
      adr_ff <= HADDR[11:0];
      if (wr_ff && adr_ff == OFS_CTRL0) begin
        en_ff <= HWDATA[C0_ENABLE];
        ch_ff <= HWDATA[C0_CHAN_LSB +: CHAN_W];
      end
      if (wr_ff && adr_ff == OFS_IRQ_EN) ien_ff <= HWDATA[0];
    end
  end
  ////////////////////////////////////////////////////////////
  property p_rd_idle; !rd_ff |-> HRDATA == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside data phase");
  property p_rd_top; rd_ff |-> HRDATA[31:8] == 24'h0; endproperty
  a_rd_top: assert property (p_rd_top)
    else $error("read data upper bits set");
  property p_mux_off; !en_ff && $past(!en_ff) |->
    !ANALOG_CTL.mux_connect; endproperty
  a_mux_off: assert property (p_mux_off)
    else $error("input connected while disabled");
  property p_chan; ANALOG_CTL.mux_connect && $stable(ch_ff) |->
    ANALOG_CTL.channel == ch_ff; endproperty
  a_chan: assert property (p_chan)
    else $error("connected channel differs");
  property p_samp; SAMPLE |-> ANALOG_CTL.mux_connect; endproperty
  a_samp: assert property (p_samp)
    else $error("sampling a cut-off input");
  property p_irq_off; !ien_ff && $past(!ien_ff) |-> !CONV_IRQ; endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt while masked");
  property p_irq_rise; $rose(CONV_IRQ) |-> ien_ff; endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt rose without enable");
  property p_wake; WAKE_REQ |-> CONV_IRQ || $past(CONV_IRQ); endproperty
  a_wake: assert property (p_wake)
    else $error("wake without interrupt");
endmodule : sar_adc_props
bind sar_adc_control sar_adc_props i_props (.SYS_CLK(SYS_CLK),
  .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HRDATA(HRDATA), .SAMPLE(SAMPLE), .ANALOG_CTL(ANALOG_CTL),
  .CONV_IRQ(CONV_IRQ), .WAKE_REQ(WAKE_REQ));
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench of the converter control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  failures++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
  import sar_adc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hwrite = 1'b0;
  logic sleep = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hready, hresp, rc, cmp, samp, irq, wake;
  analog_ctl_t actl;
  logic [RES_W-1:0] dac;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  logic [2:0] cks [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
  // Full scale goes with the divide-by-two clock: its bit time is shorter
  // than the comparator path, so only an input above every code is exact.
  logic [4:0] channel_select [7] = '{CH_REF_POS, CH_PIN_LO, CH_PIN_LO8, CH_PIN_HI,
    CH_TEMP, CH_FIXED_REF, 5'h00};
  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  sar_adc_control #(.INSTR_CYCLES(4)) i_dut (
    .SYS_CLK(clk), .RST_N(rst_n), .HSEL(1'b1), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(HSIZE_WORD),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .RC_TICK(rc),
    .SLEEP_REQ(sleep), .COMPARE_HIGH(cmp), .ANALOG_CTL(actl),
    .DAC_CODE(dac), .SAMPLE(samp), .CONV_IRQ(irq), .WAKE_REQ(wake));
  sar_adc_analog i_src (.SYS_CLK(clk), .ANALOG_CTL(actl),
    .DAC_CODE(dac), .COMPARE_HIGH(cmp), .RC_TICK(rc));
  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  task automatic give_up();
    failures++;
    $display("[ERR] wait exp done got limit");
    stop_test();
  endtask : give_up
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    rd = hrdata;
    if (hready !== 1'b1) give_up();
  endtask : bus
  task automatic chk(input logic [11:0] a, input logic [31:0] e,
    input string nm);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
    `CHK("hresp", 1'b0, hresp)
  endtask : chk
  function automatic logic [9:0] lvl(input logic [4:0] c);
    if (c == CH_REF_POS) return 10'h3FF;
    if (c == CH_REF_NEG) return 10'h000;
    return {c, ~c};
  endfunction : lvl
  // One conversion; the RC clock is 40 system clocks per period.
  task automatic conv(input logic [2:0] ck, input logic j,
    input logic [4:0] ch, input logic [1:0] rf);
    logic [9:0] v;
    int lo, n, t0;
    v = lvl(ch);
    // An RC tick may fall right after the start, so 22 periods are sure.
    lo = ck[1:0] == 2'h3 ? 22 * 40 : 23 * (1 << {ck[1], ck[0], ck[2]});
    bus(1'b1, OFS_CTRL1, {24'h0, j, ck, 2'h0, rf});
    bus(1'b1, OFS_CTRL0, {25'h0, ch, 2'h1});
    bus(1'b1, OFS_FLAG, 32'h0);
    repeat (ch == CH_TEMP ? 10000 : 20) @(posedge clk);
    `CHK("analog ctl", {ch, 1'b1, rf}, actl)
    bus(1'b1, OFS_CTRL0, {25'h0, ch, 2'h3});
    t0 = cyc;
    n = 0;
    do begin
      bus(1'b0, OFS_CTRL0, 32'h0);
      n++;
    end while (rd[C0_GO] !== 1'b0 && n < 3000);
    if (n >= 3000) give_up();
    `CHK("conv time", 1'b1, cyc - t0 >= lo && cyc - t0 <= lo + 99)
    chk(OFS_FLAG, 32'h1, "done flag");
    `CHK("dac code", v, dac)
    chk(OFS_RES_HIGH, j ? {30'h0, v[9:8]} : {24'h0, v[9:2]},
      "res high");
    chk(OFS_RES_LOW, j ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h0},
      "res low");
  endtask : conv
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    chk(OFS_CTRL0, 32'h0, "ctrl0 reset");
    chk(OFS_CTRL1, 32'h0, "ctrl1 reset");
    chk(OFS_FLAG, 32'h0, "flag reset");
    chk(OFS_VREF, 32'h40, "vref reset");
    bus(1'b1, 12'h100, 32'hFF);
    chk(12'h100, 32'h0, "unmapped");
    bus(1'b1, OFS_VREF, 32'hFF);
    chk(OFS_VREF, 32'hF3, "vref access");
    bus(1'b1, OFS_CTRL0, 32'h3);
    chk(OFS_CTRL0, 32'h1, "go with enable");
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      conv(cks[i], i[0], channel_select[i], i[1:0] == 2'h1 ? 2'h0 : i[1:0]);
    end
    $display("test conversions done");
    bus(1'b1, OFS_IRQ_EN, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("irq on", 1'b1, irq)
    bus(1'b1, OFS_FLAG, 32'h0);
    repeat (2) @(posedge clk);
    `CHK("irq off", 1'b0, irq)
    $display("test interrupt done");
    sleep <= 1'b1;
    conv(3'h7, 1'b1, CH_REF_NEG, 2'h2);
    `CHK("wake", 1'b1, wake)
    sleep <= 1'b0;
    bus(1'b1, OFS_FLAG, 32'h0);
    bus(1'b1, OFS_CTRL1, 32'hE0);
    bus(1'b1, OFS_CTRL0, {25'h0, CH_REF_NEG, 2'h3});
    repeat (100) @(posedge clk);
    sleep <= 1'b1;
    repeat (10) @(posedge clk);
    chk(OFS_CTRL0, {25'h0, CH_REF_NEG, 2'h1}, "sleep abort");
    chk(OFS_FLAG, 32'h0, "sleep no done");
    sleep <= 1'b0;
    $display("test sleep done");
    bus(1'b1, OFS_CTRL0, {25'h0, CH_REF_POS, 2'h1});
    repeat (20) @(posedge clk);
    bus(1'b1, OFS_CTRL0, {25'h0, CH_REF_POS, 2'h3});
    repeat (300) @(posedge clk);
    bus(1'b1, OFS_CTRL0, {25'h0, CH_REF_POS, 2'h1});
    chk(OFS_CTRL0, {25'h0, CH_REF_POS, 2'h1}, "abort go");
    chk(OFS_RES_HIGH, 32'h3, "abort high");
    chk(OFS_RES_LOW, 32'hFF, "abort low");
    $display("test abort done");
    bus(1'b1, OFS_CTRL0, {25'h0, CH_REF_POS, 2'h0});
    repeat (2) @(posedge clk);
    `CHK("mux off", 1'b0, actl.mux_connect)
    `CHK("sample off", 1'b0, samp)
    chk(OFS_MODE, 32'h0, "status idle");
    $display("test disable done");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
